// ### rtl/stc_top.sv
// Storage trap and cache check logic: shared misses, I/O addressing, DMA invalidate, traps.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Shared selected entry forces the next miss.
// - Shared bit follows entry, update writes it; checked unless misses suppressed.
// - Shared effect immediate, no data invalidation.
// - Each set holds 32 page leaves.
// - I/O request zeroes data bus bits 05-14.
// - Transfer code plus memory dest invalidates line.
// - Mapped I/O leaf bits replace address 02-06.
// - Priority: register-file, translation miss, violation.
// - Low register-file reads abort, load cache.
// - Loaded entry invalid, retry suppresses misses.
// - Segment or page mismatch raises translation miss.
// - Clear valid bit raises translation miss.
// - Process ID checked for private segments only.
// - Ring 1 and 3 rights; ring 0 granted.
// - Operation beyond rights raises violation.
// - Violation only on tag match.
module stc_top
  import stc_pkg::*;
#(
  parameter int unsigned LEAVES = stc_pkg::STC_LEAVES  // Leaves per cache set.
) (
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // Microinstruction controls.
  input  wire logic                  io_zero_req_i,      // Auxiliary control asks for I/O address support.
  input  wire logic                  dmx_code_i,         // Direct memory transfer auxiliary code.
  input  wire logic                  mem_dest_i,         // Microinstruction has a memory destination.
  input  wire logic                  addr_low_dest_i,    // Copy-to-address-low destination.
  input  wire logic                  mapped_io_i,        // Mapped I/O operation in progress.
  input  wire logic                  load_addr_i,        // Load the cache address register.
  input  wire logic                  retry_i,            // Current microstep is a trap retry.
  input  stc_pkg::stc_mode_t         mode_i,             // Current addressing mode.
  input  wire logic [STC_PID_W-1:0]  process_identifier_i,
  // Data paths.
  input  wire logic [15:0]           data_bus_high_i,
  input  wire logic [STC_ADDR_W-1:0] operand_cache_address_low_i,
  input  wire logic [STC_LEAF_W-1:0] mapped_io_leaf_bits_i,
  // Translation buffer.
  input  wire logic                  tlb_update_i,       // Translation buffer written this cycle.
  input  wire logic                  tlb_update_shared_i,
  input  stc_pkg::stc_entry_t        tlb_entry_i,        // Selected entry, shared flag as read.
  input  wire logic                  tag_hit_i,          // Cache tag matched.
  // Reference.
  input  stc_pkg::stc_ref_t          ref_i,
  // Cache controls.
  output logic [STC_ADDR_W-1:0]      cache_address_register_o,
  output logic                       cache_miss_o,       // Reference misses.
  output logic                       invalidate_o,       // Invalidate line at the cache address.
  output logic                       rf_load_o,          // Load cache entry from register file.
  output logic                       rf_load_invalid_o,  // That loaded entry is marked invalid.
  output logic [STC_LEAF_W-1:0]      leaf_o,             // Leaf index of the current address.
  // Trap report.
  output stc_pkg::stc_trap_t         trap_o,
  output logic                       trap_valid_o
);

  // ****************************************************************
  // Local state
  // ****************************************************************
  logic [STC_ADDR_W-1:0] addr_q;        // Cache address register.
  logic [STC_ADDR_W-1:0] addr_d;        // Its next value.
  logic                  shared_q;      // Shared flag of the selected element.
  logic                  suppress_q;    // Misses held off for the retried microstep.
  logic [STC_ADDR_W-1:0] op_addr;       // Operand address after the leaf mux.
  logic [15:0]           bus_masked;    // Data bus high with I/O bits cleared.
  logic                  rf_hit;        // Register-file address detected.
  logic                  xlate_miss;    // Translation miss detected.
  logic                  acv_raw;       // Rights check result.
  logic                  acv;           // Violation qualified by tag match.
  logic                  seg_private;   // Segment lies in private space.
  stc_trap_t             trap_d;        // Prioritised trap.

  // ****************************************************************
  // Cache address path
  // ****************************************************************
  // Clearing the middle bits keeps I/O addresses in the low segments.
  always_comb begin
    bus_masked = data_bus_high_i;
    if (io_zero_req_i) begin
      bus_masked[STC_IOZ_HI:STC_IOZ_LO] = '0;
    end
  end

  // The leaf bits come from the I/O map so the page that the data really
  // lands in is the one invalidated, not the alias.
  always_comb begin
    op_addr = operand_cache_address_low_i;
    if (mapped_io_i) begin
      op_addr[STC_LEAF_HI:STC_LEAF_LO] = mapped_io_leaf_bits_i;
    end
  end

  // The address-low destination takes the muxed operand address; a plain load takes the bus.
  always_comb begin
    addr_d = addr_q;
    if (addr_low_dest_i) begin
      addr_d = op_addr;
    end else if (load_addr_i) begin
      addr_d = bus_masked;
    end
  end

  // Cache address register.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_q <= '0;
    end else begin
      addr_q <= addr_d;
    end
  end

  assign cache_address_register_o = addr_q;
  // Each set is split into page-sized leaves indexed by these bits.
  assign leaf_o = addr_q[STC_LEAF_HI:STC_LEAF_LO];

  // ****************************************************************
  // Line invalidation for direct memory input
  // ****************************************************************
  // Registered so the line named by the address register is invalidated.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      invalidate_o <= 1'b0;
    end else begin
      invalidate_o <= dmx_code_i & mem_dest_i;
    end
  end

  // ****************************************************************
  // Shared flag and miss forcing
  // ****************************************************************
  // The flag follows the selected element each cycle, and an update
  // writes the new value straight in, so a change acts on the next reference.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      shared_q <= 1'b0;
    end else if (tlb_update_i) begin
      shared_q <= tlb_update_shared_i;
    end else begin
      shared_q <= tlb_entry_i.shared;
    end
  end

  // Tag match is overridden by the shared flag; cached data is left valid.
  always_comb begin
    if (suppress_q) begin
      cache_miss_o = 1'b0;
    end else begin
      cache_miss_o = ref_i.valid & (~tag_hit_i | shared_q);
    end
  end

  // ****************************************************************
  // Trap detection
  // ****************************************************************
  // Register-file addresses are never in I mode.
  always_comb begin
    unique case (mode_i)
      STC_MODE_V: rf_hit = ref_i.valid & ref_i.rd & (ref_i.ea <= STC_RF_TOP_V);
      STC_MODE_S,
      STC_MODE_R: rf_hit = ref_i.valid & ref_i.rd & (ref_i.ea <= STC_RF_TOP_SR);
      STC_MODE_I: rf_hit = 1'b0;
    endcase
  end

  assign seg_private = (ref_i.seg >= STC_PRIV_SEG);

  // Translation miss: tag mismatch, invalid entry, or private PROCESS_IDENTIFIER mismatch.
  always_comb begin
    xlate_miss = 1'b0;
    if ((ref_i.seg != tlb_entry_i.seg) || (ref_i.page != tlb_entry_i.page)) begin
      xlate_miss = 1'b1;
    end
    if (!tlb_entry_i.valid) begin
      xlate_miss = 1'b1;
    end
    if (seg_private && (tlb_entry_i.process_identifier != process_identifier_i)) begin
      xlate_miss = 1'b1;
    end
    xlate_miss = xlate_miss & ref_i.valid;
  end

  // Rights comparison lives in its own leaf.
  stc_rights_check u_rights (
    .rd_i        (ref_i.rd),
    .wr_i        (ref_i.wr),
    .exec_i      (ref_i.exec),
    .ring_i      (ref_i.ring),
    .ring1_i     (tlb_entry_i.ring1),
    .ring3_i     (tlb_entry_i.ring3),
    .violation_o (acv_raw)
  );

  // A violation without a tag match is meaningless and is dropped here.
  assign acv = ref_i.valid & acv_raw & ~xlate_miss;

  // Fixed priority encoder, one trap reported.
  always_comb begin
    if (rf_hit) begin
      trap_d = STC_TRAP_RFA;
    end else if (xlate_miss) begin
      trap_d = STC_TRAP_MISS;
    end else if (acv) begin
      trap_d = STC_TRAP_ACV;
    end else begin
      trap_d = STC_TRAP_NONE;
    end
  end

  // Trap report register.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      trap_o       <= STC_TRAP_NONE;
      trap_valid_o <= 1'b0;
    end else begin
      trap_o       <= trap_d;
      trap_valid_o <= (trap_d != STC_TRAP_NONE);
    end
  end

  // Register-file trap: load the entry invalid and hold off misses on retry.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rf_load_o         <= 1'b0;
      rf_load_invalid_o <= 1'b0;
    end else begin
      rf_load_o         <= rf_hit;
      rf_load_invalid_o <= rf_hit;
    end
  end

  // Suppression arms on the trap and lasts through the retried microstep only.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      suppress_q <= 1'b0;
    end else if (rf_hit) begin
      suppress_q <= 1'b1;
    end else if (retry_i) begin
      suppress_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_shared_miss;
    @(posedge clk_i) disable iff (sys_rst_i)
      (shared_q && ref_i.valid && !suppress_q) |-> cache_miss_o;
  endproperty
  a_shared_miss: assert property (p_shared_miss) else $error("Shared flag did not force a miss.");

  property p_shared_follow;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!tlb_update_i) |=> (shared_q == $past(tlb_entry_i.shared));
  endproperty
  a_shared_follow: assert property (p_shared_follow) else $error("Shared flag did not follow entry.");

  property p_io_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      (io_zero_req_i && load_addr_i && !addr_low_dest_i) |=> (addr_q[14:5] == 10'h000);
  endproperty
  a_io_zero: assert property (p_io_zero) else $error("I/O bits not cleared.");

  property p_invalidate;
    @(posedge clk_i) disable iff (sys_rst_i)
      (dmx_code_i && mem_dest_i) |=> invalidate_o;
  endproperty
  a_invalidate: assert property (p_invalidate) else $error("Transfer did not invalidate.");

  property p_leaf_mux;
    @(posedge clk_i) disable iff (sys_rst_i)
      (mapped_io_i && addr_low_dest_i) |=> (leaf_o == $past(mapped_io_leaf_bits_i));
  endproperty
  a_leaf_mux: assert property (p_leaf_mux) else $error("Leaf bits not merged.");

  property p_prio;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rf_hit && xlate_miss) |=> (trap_o == STC_TRAP_RFA);
  endproperty
  a_prio: assert property (p_prio) else $error("Wrong trap priority.");

  property p_invalid_miss;
    @(posedge clk_i) disable iff (sys_rst_i)
      (ref_i.valid && !tlb_entry_i.valid && !rf_hit) |=> (trap_o == STC_TRAP_MISS);
  endproperty
  a_invalid_miss: assert property (p_invalid_miss) else $error("Invalid entry not trapped.");

  property p_suppress;
    @(posedge clk_i) disable iff (sys_rst_i)
      rf_hit |=> (!cache_miss_o && rf_load_invalid_o);
  endproperty
  a_suppress: assert property (p_suppress) else $error("Retry misses not suppressed.");

  property p_ring0;
    @(posedge clk_i) disable iff (sys_rst_i)
      (ref_i.ring == 2'b00) |=> (trap_o != STC_TRAP_ACV);
  endproperty
  a_ring0: assert property (p_ring0) else $error("Ring 0 violation reported.");

  c_rf_trap: cover property (@(posedge clk_i) disable iff (sys_rst_i) rf_hit ##1 retry_i);
  c_shared:  cover property (@(posedge clk_i) disable iff (sys_rst_i) shared_q && tag_hit_i && ref_i.valid);
  c_acv:     cover property (@(posedge clk_i) disable iff (sys_rst_i) trap_d == STC_TRAP_ACV);
  c_dmx:     cover property (@(posedge clk_i) disable iff (sys_rst_i) dmx_code_i && addr_low_dest_i && mapped_io_i);

endmodule  // stc_top

// ### rtl/stc_pkg.sv
// Package of constants and carrier types for the storage trap and cache check block.
package stc_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned STC_LEAVES      = 32;        // Leaves per cache set, one per physical page.
  localparam int unsigned STC_LEAF_W      = 5;         // Width of a leaf index.
  localparam int unsigned STC_SEG_W       = 12;        // Segment number width.
  localparam int unsigned STC_PAGE_W      = 6;         // Page number width held in an entry.
  localparam int unsigned STC_PID_W       = 10;        // Process identifier width.
  localparam int unsigned STC_ADDR_W      = 16;        // Cache address register width.
  localparam int unsigned STC_EA_W        = 16;        // Effective address width.

  // ****************************************************************
  // Field positions and bounds
  // ****************************************************************
  localparam int unsigned STC_IOZ_LO      = 5;         // Lowest data bus high bit forced to zero.
  localparam int unsigned STC_IOZ_HI      = 14;        // Highest data bus high bit forced to zero.
  localparam int unsigned STC_LEAF_LO     = 2;         // Lowest operand address bit swapped for the leaf.
  localparam int unsigned STC_LEAF_HI     = 6;         // Highest operand address bit swapped for the leaf.
  localparam logic [15:0] STC_RF_TOP_V    = 16'h0007;  // Last register-file address in V mode.
  localparam logic [15:0] STC_RF_TOP_SR   = 16'h001F;  // Last register-file address in S or R mode.
  localparam logic [11:0] STC_PRIV_SEG    = 12'h800;   // First private segment, octal 4000.

  // ****************************************************************
  // Addressing modes and trap codes
  // ****************************************************************
  typedef enum logic [1:0] {
    STC_MODE_S = 2'b00,
    STC_MODE_R = 2'b01,
    STC_MODE_V = 2'b10,
    STC_MODE_I = 2'b11
  } stc_mode_t;

  typedef enum logic [1:0] {
    STC_TRAP_NONE = 2'b00,
    STC_TRAP_RFA  = 2'b01,
    STC_TRAP_MISS = 2'b10,
    STC_TRAP_ACV  = 2'b11
  } stc_trap_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Access rights for one ring.
  typedef struct packed {
    logic exec;
    logic wr;
    logic rd;
  } stc_rights_t;

  // One translation entry as seen by the checker.
  typedef struct packed {
    logic                 valid;
    logic                 shared;
    logic [STC_SEG_W-1:0] seg;
    logic [STC_PAGE_W-1:0] page;
    logic [STC_PID_W-1:0] process_identifier;
    stc_rights_t          ring1;
    stc_rights_t          ring3;
  } stc_entry_t;

  // One storage reference request.
  typedef struct packed {
    logic                  valid;
    logic                  rd;
    logic                  wr;
    logic                  exec;
    logic [1:0]            ring;
    logic [STC_SEG_W-1:0]  seg;
    logic [STC_PAGE_W-1:0] page;
    logic [STC_EA_W-1:0]   ea;
  } stc_ref_t;

endpackage : stc_pkg

// ### rtl/stc_rights_check.sv
// Ring-based access rights checker for one reference.
`timescale 1ns/1ps
module stc_rights_check
  import stc_pkg::*;
(
  // Reference and rights.
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic        exec_i,
  input  wire logic [1:0]  ring_i,
  input  stc_pkg::stc_rights_t ring1_i,
  input  stc_pkg::stc_rights_t ring3_i,
  // Result.
  output logic             violation_o
);

  // ****************************************************************
  // Rights selection and compare
  // ****************************************************************
  stc_rights_t sel;  // Rights of the referencing ring.

  // Ring 0 is always granted; ring 1 and ring 3 use their own fields.
  always_comb begin
    sel = ring3_i;
    if (ring_i == 2'b01) begin
      sel = ring1_i;
    end
    if (ring_i == 2'b00) begin
      violation_o = 1'b0;
    end else begin
      // Any requested operation absent from the rights is a violation.
      violation_o = (rd_i & ~sel.rd) | (wr_i & ~sel.wr) | (exec_i & ~sel.exec);
    end
  end

endmodule  // stc_rights_check

// ### dv/stc_ucode_model.sv
// Behavioural model of the microcode sequencer's trap handlers.
`timescale 1ns/1ps
module stc_ucode_model
  import stc_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  // Trap report from the block.
  input  stc_pkg::stc_trap_t trap_i,
  input  wire logic          trap_valid_i,
  // Handler actions.
  output logic               tlb_update_o,
  output logic               retry_o
);
  logic reload_q;  // A translation was reloaded last cycle.

  // ************************************************************
  // Handlers
  // ************************************************************
  // A miss handler writes the new translation at once.
  assign tlb_update_o = trap_valid_i && (trap_i == STC_TRAP_MISS);

  // Remember the reload so the retry comes only after it.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= tlb_update_o;
    end
  end

  // A register-file trap is retried in the very next microstep.
  assign retry_o = (trap_valid_i && (trap_i == STC_TRAP_RFA)) || reload_q;
endmodule  // stc_ucode_model

// ### dv/stc_top_tb.sv
// Self-checking random testbench for the storage trap and cache check block.
`timescale 1ns/1ps
module stc_top_tb;
  import stc_pkg::*;
  localparam int unsigned N_CYC = 3000;  // Random cycles; each one is checked.

  // ************************************************************
  // Signals and model state
  // ************************************************************
  logic        clk_i, sys_rst_i, io_zero_req_i, dmx_code_i, mem_dest_i, addr_low_dest_i;
  logic        mapped_io_i, load_addr_i, retry_i, tlb_update_i, tlb_update_shared_i, tag_hit_i;
  logic        invalidate_o, rf_load_o, rf_load_invalid_o, cache_miss_o, trap_valid_o;
  logic [9:0]  process_identifier_i;
  logic [15:0] data_bus_high_i, operand_cache_address_low_i, cache_address_register_o, e_car;
  logic [4:0]  mapped_io_leaf_bits_i, leaf_o;
  stc_mode_t   mode_i;
  stc_entry_t  tlb_entry_i;
  stc_ref_t    ref_i;
  stc_trap_t   trap_o, e_trap;
  logic        e_inv, e_shared, e_sup;  // Expected state carried to the next cycle.
  int          n_fail, checks_done;

  stc_top i_stc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .io_zero_req_i(io_zero_req_i),
    .dmx_code_i(dmx_code_i), .mem_dest_i(mem_dest_i), .addr_low_dest_i(addr_low_dest_i),
    .mapped_io_i(mapped_io_i), .load_addr_i(load_addr_i), .retry_i(retry_i), .mode_i(mode_i),
    .process_identifier_i(process_identifier_i), .data_bus_high_i(data_bus_high_i),
    .operand_cache_address_low_i(operand_cache_address_low_i),
    .mapped_io_leaf_bits_i(mapped_io_leaf_bits_i), .tlb_update_i(tlb_update_i),
    .tlb_update_shared_i(tlb_update_shared_i), .tlb_entry_i(tlb_entry_i), .tag_hit_i(tag_hit_i),
    .ref_i(ref_i), .cache_address_register_o(cache_address_register_o), .cache_miss_o(cache_miss_o),
    .invalidate_o(invalidate_o), .rf_load_o(rf_load_o), .rf_load_invalid_o(rf_load_invalid_o),
    .leaf_o(leaf_o), .trap_o(trap_o), .trap_valid_o(trap_valid_o));

  stc_ucode_model i_stc_ucode_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .trap_i(trap_o),
    .trap_valid_i(trap_valid_o), .tlb_update_o(tlb_update_i), .retry_o(retry_i));

  // ************************************************************
  // Model and compare tasks
  // ************************************************************
  // Trap that the reference should raise; the order of tests is the priority.
  function automatic stc_trap_t model_trap(stc_ref_t r, stc_entry_t e, stc_mode_t m, logic [9:0] p);
    stc_rights_t a;
    a = (r.ring == 2'h1) ? e.ring1 : e.ring3;
    if (!r.valid) return STC_TRAP_NONE;
    if (r.rd && ((m == STC_MODE_V && r.ea <= 16'h0007) ||
        ((m == STC_MODE_S || m == STC_MODE_R) && r.ea <= 16'h001F))) return STC_TRAP_RFA;
    if (!e.valid || r.seg != e.seg || r.page != e.page) return STC_TRAP_MISS;
    if (r.seg >= 12'h800 && p != e.process_identifier) return STC_TRAP_MISS;
    if (r.ring != 2'h0 && ((r.rd && !a.rd) || (r.wr && !a.wr) || (r.exec && !a.exec)))
      return STC_TRAP_ACV;
    return STC_TRAP_NONE;
  endfunction

  task automatic chk_trap(input stc_trap_t got, input stc_trap_t exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t trap code %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s is %b, expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s is %h, expected %h", $time, what, got, exp);
    end
  endtask

  // New random microinstruction and reference, driven just after the edge.
  task automatic drive_random();
    stc_entry_t e;
    stc_ref_t   r;
    logic       xfer;
    int         op;
    e.valid  = ($urandom % 8) != 0;
    e.shared = ($urandom % 4) == 0;
    e.seg    = 12'($urandom);
    e.page   = 6'($urandom);
    e.process_identifier    = 10'($urandom);
    e.ring1  = 3'($urandom);
    e.ring3  = 3'($urandom);
    op       = $urandom % 3;
    r.valid  = ($urandom % 8) != 0;
    r.rd     = (op == 0);
    r.wr     = (op == 1);
    r.exec   = (op == 2);
    r.ring   = ($urandom % 3 == 0) ? 2'h0 : (($urandom % 2 == 0) ? 2'h1 : 2'h3);
    r.seg    = ($urandom % 4 == 0) ? 12'($urandom) : e.seg;
    r.page   = ($urandom % 4 == 0) ? 6'($urandom) : e.page;
    r.ea     = ($urandom % 2 == 0) ? 16'($urandom % 48) : 16'($urandom);
    xfer     = ($urandom % 4) == 0;
    // Transfers stay inside the first four segments, as the microcode keeps them.
    if (xfer) r.seg = 12'($urandom % 4);
    ref_i                       <= r;
    tlb_entry_i                 <= e;
    mode_i                      <= stc_mode_t'(2'($urandom));
    process_identifier_i        <= ($urandom % 4 == 0) ? 10'($urandom) : e.process_identifier;
    tag_hit_i                   <= ($urandom % 4) != 0;
    tlb_update_shared_i         <= 1'($urandom);
    io_zero_req_i               <= 1'($urandom);
    data_bus_high_i             <= 16'($urandom);
    load_addr_i                 <= 1'($urandom);
    operand_cache_address_low_i <= 16'($urandom);
    mapped_io_leaf_bits_i       <= 5'($urandom);
    // An input transfer pairs the transfer code with the address-low copy.
    dmx_code_i                  <= xfer | (($urandom % 8) == 0);
    mem_dest_i                  <= xfer | 1'($urandom);
    addr_low_dest_i             <= xfer | (($urandom % 4) == 0);
    mapped_io_i                 <= xfer | 1'($urandom);
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // The run needs about N_CYC cycles; twice that means a hang.
  initial begin
    #(N_CYC * 8 + 1000);
    n_fail++;
    wrap_up();
  end

  initial begin
    sys_rst_i = 1'b1;
    {io_zero_req_i, dmx_code_i, mem_dest_i, addr_low_dest_i, mapped_io_i, load_addr_i} = '0;
    {tlb_update_shared_i, tag_hit_i, process_identifier_i, data_bus_high_i} = '0;
    {operand_cache_address_low_i, mapped_io_leaf_bits_i} = '0;
    mode_i = STC_MODE_S;
    tlb_entry_i = '0;
    ref_i = '0;
    {e_inv, e_shared, e_sup, e_car, n_fail, checks_done} = '0;
    e_trap = STC_TRAP_NONE;
    void'($urandom(32'hC97E968B));
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (N_CYC) begin
      @(posedge clk_i);
      drive_random();
      #1;
      // Registered results of last cycle, and the same-cycle miss decision.
      chk_trap(trap_o, e_trap);
      chk_bit(trap_valid_o, e_trap != STC_TRAP_NONE, "trap valid");
      chk_bit(rf_load_o, e_trap == STC_TRAP_RFA, "rf load");
      chk_bit(rf_load_invalid_o, e_trap == STC_TRAP_RFA, "rf load invalid");
      chk_bit(invalidate_o, e_inv, "invalidate");
      chk_word(cache_address_register_o, e_car, "cache address");
      chk_word({11'h000, leaf_o}, {11'h000, e_car[6:2]}, "leaf");
      chk_bit(cache_miss_o, ref_i.valid && (!tag_hit_i || e_shared) && !e_sup, "miss");
      // Work out what this cycle's inputs must produce at the next edge.
      e_trap   = model_trap(ref_i, tlb_entry_i, mode_i, process_identifier_i);
      e_shared = tlb_update_i ? tlb_update_shared_i : tlb_entry_i.shared;
      e_sup    = (e_trap == STC_TRAP_RFA);
      e_inv    = dmx_code_i && mem_dest_i;
      if (addr_low_dest_i) begin
        e_car = operand_cache_address_low_i;
        if (mapped_io_i) e_car[6:2] = mapped_io_leaf_bits_i;
      end else if (load_addr_i) begin
        e_car = data_bus_high_i;
        if (io_zero_req_i) e_car[14:5] = 10'h000;
      end
    end
    wrap_up();
  end
endmodule  // stc_top_tb
